// [logic/sapd_decoder.sv]
// slot access policy decoder with ahb-lite register slave
// Overview of operation
// - unlocked data zone: writes allowed, reads refused
// - one policy word per slot, applied
// - bits 0-3 read key; zero allows mac copy
// - verify bit limits key to mac compare
// - limited-use bit ignored for slots 8-14
// - cipher bit: encrypted read, no mac
// - confidential: no clear reads, no 4-byte access
// - bits 8-11 select write auth key
// - both bits clear: clear reads 4/32
// - confidential only: reads refused, key usable
// - both set: encrypt with read key slot
// - code 000x: clear writes allowed
// - code 001x or 10xx: writes refused
// - bit 14: mac and encrypted, no 4-byte
// - derive refused when bit 13 clear
// - bit 12 picks target or parent source
// - bit 15 demands derive authorizing mac
// - write and derive decoded independently
// - zone unlocked only when lock byte 0x55
// - config unlocked: data access refused
`timescale 1ns/100ps
`default_nettype none
module sapd_decoder
  import sapd_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic req_valid,
  input wire logic [2:0] req_cmd,
  input wire logic req_short,
  input wire logic [3:0] req_slot,
  input wire logic req_digest_for_mac,
  output logic dec_valid_q,
  output logic dec_permit_q,
  output logic dec_deny_q,
  output logic dec_encrypt_q,
  output logic dec_need_mac_q,
  output logic dec_limited_q,
  output logic dec_copy_ok_q,
  output logic [3:0] dec_key_slot_q
);
  logic [POL_W-1:0] policy_q [NUM_SLOTS];
  logic [7:0] zone_lock_q;
  logic [7:0] cfg_lock_q;
  logic ap_wr_q;
  logic [11:0] ap_addr_q;
  logic [POL_W-1:0] pol;
  logic zone_unl;
  logic cfg_unl;
  logic conf;
  logic ciph;
  logic [3:0] mode;
  logic permit_d;
  logic encrypt_d;
  logic need_mac_d;
  logic [3:0] key_d;
  logic limited_d;
  logic copy_d;
  logic ap_take;
  logic [31:0] rd_d;

  assign ap_take = hsel & hready & htrans[1];

  // address phase capture; slave never inserts wait states
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ap_wr_q <= 1'b0;
      ap_addr_q <= 12'h000;
    end
    else
    begin
      ap_wr_q <= ap_take & hwrite;
      ap_addr_q <= haddr[11:0];
    end
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      hreadyout <= 1'b1;
      hresp <= AHB_OKAY[0];
    end
  end

  // policy table, one word per slot
  for (genvar i = 0; i < NUM_SLOTS; i++)
  begin : g_pol
    localparam logic [11:0] SLOT_ADDR = 12'(POLICY_BASE + 12'(4 * i));
    always_ff @(posedge hclk or negedge hresetn)
    begin
      if (!hresetn)
        policy_q[i] <= POLICY_RESET;
      else if (ap_wr_q && ap_addr_q == SLOT_ADDR)
        policy_q[i] <= hwdata[POL_W-1:0];
    end
  end

  // lock bytes; locking is one-way, a locked byte cannot be unlocked again
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      zone_lock_q <= LOCK_RESET;
      cfg_lock_q <= LOCK_RESET;
    end
    else if (ap_wr_q && ap_addr_q == LOCK_ADDR)
    begin
      if (zone_lock_q == UNLOCKED_VAL)
        zone_lock_q <= hwdata[7:0];
      if (cfg_lock_q == UNLOCKED_VAL)
        cfg_lock_q <= hwdata[15:8];
    end
  end

  // read mux decoded in the address phase so hrdata stands from a flop in the data phase
  always_comb
  begin
    rd_d = 32'h0000_0000;
    if (haddr[11:0] >= POLICY_BASE && haddr[11:0] <= POLICY_LAST && haddr[1:0] == 2'b00)
      rd_d = {16'h0000, policy_q[4'((haddr[11:0] - POLICY_BASE) >> 2)]};
    else if (haddr[11:0] == LOCK_ADDR)
      rd_d = {16'h0000, cfg_lock_q, zone_lock_q};
    else if (haddr[11:0] == STATUS_ADDR)
      rd_d = {24'h000000, dec_key_slot_q, dec_encrypt_q, dec_need_mac_q, dec_deny_q,
              dec_permit_q};
  end

  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
      hrdata <= 32'h0000_0000;
    else if (ap_take && !hwrite)
      hrdata <= rd_d;
  end

  // policy decode
  assign pol = policy_q[req_slot];
  assign zone_unl = (zone_lock_q == UNLOCKED_VAL);
  assign cfg_unl = (cfg_lock_q == UNLOCKED_VAL);
  assign conf = pol[CONF_BIT];
  assign ciph = pol[CIPHER_BIT];
  assign mode = pol[MOD_LSB +: 4];

  always_comb
  begin
    permit_d = 1'b0;
    encrypt_d = 1'b0;
    need_mac_d = 1'b0;
    key_d = req_slot;
    limited_d = 1'b0;
    copy_d = 1'b0;
    // verify-restricted keys are not gated for read/write data access
    case (sapd_cmd_e'(req_cmd))
      SAPD_CMD_READ:
      begin
        key_d = pol[RKEY_LSB +: 4];
        if (cfg_unl)
          permit_d = 1'b0;
        else if (zone_unl)
          permit_d = 1'b0;
        else if (!conf && !ciph)
          permit_d = 1'b1;
        else if (conf && !ciph)
          permit_d = 1'b0;
        else if (conf && ciph)
        begin
          // cipher without confidential is refused: no protection given
          permit_d = !req_short;
          encrypt_d = 1'b1;
        end
      end
      SAPD_CMD_WRITE:
      begin
        key_d = pol[WKEY_LSB +: 4];
        if (cfg_unl)
          permit_d = 1'b0;
        else if (zone_unl)
          permit_d = 1'b1;
        else if (mode[2])
        begin
          permit_d = !req_short && !(conf && req_short);
          encrypt_d = 1'b1;
          need_mac_d = 1'b1;
        end
        else if (mode[3] || mode[1])
          permit_d = 1'b0;
        else
          permit_d = !(conf && req_short);
      end
      SAPD_CMD_DERIVE:
      begin
        // decoded on its own, independent of the write decode
        if (cfg_unl || zone_unl)
          permit_d = 1'b0;
        else if (!mode[1])
          permit_d = 1'b0;
        else
        begin
          permit_d = 1'b1;
          key_d = mode[0] ? pol[WKEY_LSB +: 4] : req_slot;
          need_mac_d = mode[3];
        end
      end
      SAPD_CMD_MAC:
      begin
        permit_d = 1'b1;
        copy_d = (pol[RKEY_LSB +: 4] == 4'h0);
      end
      SAPD_CMD_DIGEST:
        permit_d = !pol[VERIFY_BIT] || req_digest_for_mac;
      default:
        permit_d = !pol[VERIFY_BIT];
    endcase
    limited_d = pol[LIMITED_BIT] &&
                !(req_slot >= LIMIT_LO_SLOT && req_slot <= LIMIT_HI_SLOT);
  end

  // registered decision, one pulse per request
  always_ff @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      dec_valid_q <= 1'b0;
      dec_permit_q <= 1'b0;
      dec_deny_q <= 1'b0;
      dec_encrypt_q <= 1'b0;
      dec_need_mac_q <= 1'b0;
      dec_limited_q <= 1'b0;
      dec_copy_ok_q <= 1'b0;
      dec_key_slot_q <= 4'h0;
    end
    else
    begin
      dec_valid_q <= req_valid;
      dec_permit_q <= req_valid & permit_d;
      dec_deny_q <= req_valid & !permit_d;
      if (req_valid)
      begin
        dec_encrypt_q <= encrypt_d & permit_d;
        dec_need_mac_q <= need_mac_d & permit_d;
        dec_limited_q <= limited_d;
        dec_copy_ok_q <= copy_d;
        dec_key_slot_q <= key_d;
      end
    end
  end

  unlocked_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && req_cmd == 3'(SAPD_CMD_READ) && zone_unl |=> dec_deny_q)
    else $error("read permitted while zone unlocked");
  unlocked_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && req_cmd == 3'(SAPD_CMD_WRITE) && zone_unl && !cfg_unl |=> dec_permit_q)
    else $error("write refused while zone unlocked");
  cfg_unlock_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && cfg_unl && req_cmd inside {3'(SAPD_CMD_READ), 3'(SAPD_CMD_WRITE)}
    |=> dec_deny_q)
    else $error("data access before config lock");
  conf_read_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && req_cmd == 3'(SAPD_CMD_READ) && conf && !ciph |=> dec_deny_q)
    else $error("confidential read permitted");
  short_conf_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && !zone_unl && conf && req_short &&
    req_cmd inside {3'(SAPD_CMD_READ), 3'(SAPD_CMD_WRITE)} |=> dec_deny_q)
    else $error("short access to confidential slot");
  never_write_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && req_cmd == 3'(SAPD_CMD_WRITE) && !zone_unl && !mode[2] &&
    (mode[3] || mode[1]) |=> dec_deny_q)
    else $error("write permitted on never slot");
  derive_bit13_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && req_cmd == 3'(SAPD_CMD_DERIVE) && !mode[1] |=> dec_deny_q)
    else $error("derive on non-target slot");
  derive_src_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && req_cmd == 3'(SAPD_CMD_DERIVE) && mode[1] && !zone_unl && !cfg_unl
    |=> dec_key_slot_q == (mode[0] ? $past(pol[WKEY_LSB +: 4]) : $past(req_slot))
        && dec_need_mac_q == $past(mode[3]))
    else $error("derive source or mac wrong");
  limited_a: assert property (@(posedge hclk) disable iff (!hresetn)
    req_valid && req_slot >= LIMIT_LO_SLOT && req_slot <= LIMIT_HI_SLOT
    |=> !dec_limited_q)
    else $error("limited flag in slots 8-14");
  deny_excl_a: assert property (@(posedge hclk) disable iff (!hresetn)
    1'b1 |-> ((dec_permit_q || dec_deny_q) == dec_valid_q) && !(dec_permit_q && dec_deny_q))
    else $error("deny not one per request");

  read_ok_c: cover property (@(posedge hclk) disable iff (!hresetn)
    dec_permit_q && dec_encrypt_q && !dec_need_mac_q);
  write_mac_c: cover property (@(posedge hclk) disable iff (!hresetn)
    dec_permit_q && dec_need_mac_q);
  deny_c: cover property (@(posedge hclk) disable iff (!hresetn) dec_deny_q ##1 dec_permit_q);
endmodule
`default_nettype wire

// [pkg/sapd_pkg.sv]
// constants and types for the slot access policy decoder
package sapd_pkg;
  localparam int unsigned NUM_SLOTS = 16;
  localparam int unsigned SLOT_W = 4;
  localparam int unsigned POL_W = 16;
  // slot policy table base, one aligned word per slot
  localparam logic [11:0] POLICY_BASE = 12'h014;
  localparam logic [11:0] POLICY_LAST = 12'h050;
  // lock register, bits 7:0 zone lock byte, bits 15:8 config lock byte
  localparam logic [11:0] LOCK_ADDR = 12'h060;
  // last decision status
  localparam logic [11:0] STATUS_ADDR = 12'h064;
  localparam logic [7:0] UNLOCKED_VAL = 8'h55;
  localparam logic [7:0] LOCK_RESET = 8'h55;
  localparam logic [15:0] POLICY_RESET = 16'h0000;
  // field positions in a policy word
  localparam int unsigned RKEY_LSB = 0;
  localparam int unsigned VERIFY_BIT = 4;
  localparam int unsigned LIMITED_BIT = 5;
  localparam int unsigned CIPHER_BIT = 6;
  localparam int unsigned CONF_BIT = 7;
  localparam int unsigned WKEY_LSB = 8;
  localparam int unsigned MOD_LSB = 12;
  localparam logic [3:0] LIMIT_LO_SLOT = 4'h8;
  localparam logic [3:0] LIMIT_HI_SLOT = 4'he;
  localparam logic [31:0] AHB_OKAY = 32'h0000_0000;
  typedef enum logic [2:0] {
    SAPD_CMD_READ,
    SAPD_CMD_WRITE,
    SAPD_CMD_DERIVE,
    SAPD_CMD_MAC,
    SAPD_CMD_DIGEST,
    SAPD_CMD_OTHER
  } sapd_cmd_e;
endpackage

// [dv/sapd_exec_model.sv]
// command executor model issuing slot access requests
`timescale 1ns/100ps
`default_nettype none
module sapd_exec_model
  import sapd_pkg::*;
(
  input wire logic hclk,
  output logic req_valid,
  output logic [2:0] req_cmd,
  output logic req_short,
  output logic [3:0] req_slot,
  output logic req_digest_for_mac,
  input wire logic dec_valid_q,
  input wire logic dec_permit_q,
  input wire logic dec_deny_q
);
  initial
  begin
    req_valid = 1'b0;
    req_cmd = 3'h0;
    req_short = 1'b0;
    req_slot = 4'h0;
    req_digest_for_mac = 1'b0;
  end
  // one request; decision sampled the cycle after it is taken
  task automatic issue(input logic [2:0] c, input logic s, input logic [3:0] sl,
    input logic d, output logic v, output logic p, output logic n);
    @(posedge hclk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_short <= s;
    req_slot <= sl;
    req_digest_for_mac <= d;
    @(posedge hclk);
    req_valid <= 1'b0;
    // scrambled after release so a stale field never helps
    req_slot <= ~sl;
    req_short <= ~s;
    #1;
    v = dec_valid_q;
    p = dec_permit_q;
    n = dec_deny_q;
  endtask
endmodule
`default_nettype wire

// [dv/tb_slot_access_policy_decoder.sv]
// self-checking bench for the slot access policy decoder
`timescale 1ns/100ps
`default_nettype none
module tb_slot_access_policy_decoder;
  import sapd_pkg::*;
  logic hclk = 1'b0;
  logic hresetn = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata, rd;
  logic hreadyout, req_valid, req_short, req_digest_for_mac;
  logic [2:0] req_cmd;
  logic [3:0] req_slot, dec_key_slot_q;
  logic dec_valid_q, dec_permit_q, dec_deny_q, dec_encrypt_q, dec_need_mac_q;
  logic dec_limited_q, dec_copy_ok_q;
  int err_count = 0;
  int checks_done = 0;
  localparam logic [2:0] RD = SAPD_CMD_READ;
  localparam logic [2:0] WR = SAPD_CMD_WRITE;
  localparam logic [2:0] DV = SAPD_CMD_DERIVE;
  localparam logic [2:0] MC = SAPD_CMD_MAC;
  localparam logic [2:0] DG = SAPD_CMD_DIGEST;
  always #20 hclk = ~hclk;
  sapd_decoder dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(), .req_valid(req_valid),
    .req_cmd(req_cmd), .req_short(req_short), .req_slot(req_slot),
    .req_digest_for_mac(req_digest_for_mac), .dec_valid_q(dec_valid_q),
    .dec_permit_q(dec_permit_q), .dec_deny_q(dec_deny_q), .dec_encrypt_q(dec_encrypt_q),
    .dec_need_mac_q(dec_need_mac_q), .dec_limited_q(dec_limited_q),
    .dec_copy_ok_q(dec_copy_ok_q), .dec_key_slot_q(dec_key_slot_q));
  sapd_exec_model exec (.hclk(hclk), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_short(req_short), .req_slot(req_slot), .req_digest_for_mac(req_digest_for_mac),
    .dec_valid_q(dec_valid_q), .dec_permit_q(dec_permit_q), .dec_deny_q(dec_deny_q));
  task automatic end_of_test;
    $display("checks %0d mismatches %0d", checks_done, err_count);
    if (err_count == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp)
    begin
      err_count++;
      $display("mismatch %s expected %h seen %h", n, exp, got);
    end
  endtask
  // single word transfer; waits on hready in both phases
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'b10;
    haddr <= {20'h0, a};
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= wd;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // x: encrypt expected for reads, need-mac for writes and derives
  task automatic dec(input logic [3:0] sl, input logic [2:0] c, input logic s, input logic d,
    input logic p, input logic [3:0] k, input logic x);
    logic v, pm, dn;
    exec.issue(c, s, sl, d, v, pm, dn);
    chk("valid", 32'(v), 32'h1);
    chk("permit", 32'(pm), 32'(p));
    chk("deny", 32'(dn), 32'(!p));
    if (p)
    begin
      chk("key", 32'(dec_key_slot_q), 32'(k));
      if (c == RD)
        chk("encrypt", 32'(dec_encrypt_q), 32'(x));
      else if (c == WR || c == DV)
        chk("need_mac", 32'(dec_need_mac_q), 32'(x));
    end
  endtask
  task automatic t_reset;
    ahb(1'b0, POLICY_BASE, 32'h0);
    chk("pol0", rd, 32'h0);
    ahb(1'b0, LOCK_ADDR, 32'h0);
    chk("lock", rd, 32'h5555);
    ahb(1'b0, 12'h070, 32'h0);
    chk("unmapped", rd, 32'h0);
    dec(4'h0, WR, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
    dec(4'h0, RD, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
  endtask
  task automatic t_zone_open;
    // key slots confidential; slot 6 updates itself in place
    logic [15:0] pol [10] = '{16'h0000, 16'h00c5, 16'h00a0, 16'h0040, 16'h2080,
      16'h8080, 16'h6680, 16'hb780, 16'h0090, 16'h00a0};
    ahb(1'b1, LOCK_ADDR, 32'h0055);
    for (int i = 0; i < 10; i++)
      ahb(1'b1, POLICY_BASE + 12'(4 * i), {16'hffff, pol[i]});
    ahb(1'b0, POLICY_BASE + 12'h018, 32'h0);
    chk("pol6", rd, 32'h6680);
    dec(4'h5, WR, 1'b0, 1'b0, 1'b1, 4'h0, 1'b0);
    dec(4'h0, RD, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
    ahb(1'b1, LOCK_ADDR, 32'h0);
    ahb(1'b1, LOCK_ADDR, 32'h5555);
    ahb(1'b0, LOCK_ADDR, 32'h0);
    chk("locked", rd, 32'h0);
  endtask
  task automatic t_read;
    dec(4'h0, RD, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0);
    dec(4'h0, MC, 1'b0, 1'b0, 1'b1, 4'h0, 1'b0);
    chk("copy0", 32'(dec_copy_ok_q), 32'h1);
    dec(4'h1, RD, 1'b0, 1'b0, 1'b1, 4'h5, 1'b1);
    dec(4'h1, MC, 1'b0, 1'b0, 1'b1, 4'h1, 1'b0);
    chk("copy1", 32'(dec_copy_ok_q), 32'h0);
    dec(4'h1, RD, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0);
    dec(4'h2, RD, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
    dec(4'h2, MC, 1'b0, 1'b0, 1'b1, 4'h2, 1'b0);
    chk("limit2", 32'(dec_limited_q), 32'h1);
    dec(4'h9, MC, 1'b0, 1'b0, 1'b1, 4'h9, 1'b0);
    chk("limit9", 32'(dec_limited_q), 32'h0);
    dec(4'h3, RD, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
  endtask
  task automatic t_write;
    dec(4'h0, WR, 1'b1, 1'b0, 1'b1, 4'h0, 1'b0);
    dec(4'h4, WR, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
    dec(4'h5, WR, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
    dec(4'h7, WR, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
    dec(4'h6, WR, 1'b0, 1'b0, 1'b1, 4'h6, 1'b1);
    dec(4'h6, WR, 1'b1, 1'b0, 1'b0, 4'h0, 1'b0);
  endtask
  task automatic t_derive;
    dec(4'h5, DV, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
    dec(4'h0, DV, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
    dec(4'h6, DV, 1'b0, 1'b0, 1'b1, 4'h6, 1'b0);
    dec(4'h4, DV, 1'b0, 1'b0, 1'b1, 4'h4, 1'b0);
    dec(4'h7, DV, 1'b0, 1'b0, 1'b1, 4'h7, 1'b1);
  endtask
  task automatic t_verify;
    dec(4'h8, MC, 1'b0, 1'b0, 1'b1, 4'h8, 1'b0);
    dec(4'h8, DG, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
    dec(4'h8, DG, 1'b0, 1'b1, 1'b1, 4'h8, 1'b0);
    dec(4'h8, SAPD_CMD_OTHER, 1'b0, 1'b0, 1'b0, 4'h0, 1'b0);
  endtask
  initial
  begin
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    t_reset();
    t_zone_open();
    t_read();
    t_write();
    t_derive();
    t_verify();
    end_of_test();
  end
  // the whole sequence needs about 120 cycles
  initial
  begin
    repeat (5000) @(posedge hclk);
    err_count++;
    end_of_test();
  end
endmodule
`default_nettype wire
